// ===== rtl/hdm_delay_line.sv
// Programmable pixel delay line of two to a fixed number of clocks.
`timescale 1ns/1ps
module hdm_delay_line #(
   parameter int unsigned W = 10,
   parameter int unsigned SW = 3,
   parameter int unsigned DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic nrst,
   hdm_dly_if.line port
);
   logic [W-1:0] stage_ff [DEPTH+1];
   logic [W-1:0] nxt_stage [DEPTH+1];
   logic [W-1:0] dout_ff;
   logic [W-1:0] nxt_dout;

   if (DEPTH < 1 || DEPTH >= (1 << SW)) begin : g_bad
      $error("Delay depth does not fit the select width.");
   end

   always_comb begin
      nxt_stage[0] = port.din;
      for (int i = 1; i <= DEPTH; i++) begin
         nxt_stage[i] = stage_ff[i-1];
      end
      // Settings above the depth clamp to the longest delay.
      if (port.dly > SW'(DEPTH)) begin
         nxt_dout = stage_ff[DEPTH];
      end else begin
         nxt_dout = stage_ff[port.dly];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i <= DEPTH; i++) begin
            stage_ff[i] <= '0;
         end
         dout_ff <= '0;
      end else begin
         stage_ff <= nxt_stage;
         dout_ff <= nxt_dout;
      end
   end

   assign port.dout = dout_ff;
endmodule // hdm_delay_line

// ===== rtl/hdm_dly_if.sv
// Interface joining the video path to one of its pixel delay lines.
`timescale 1ns/1ps
interface hdm_dly_if #(parameter int unsigned W = 10, parameter int unsigned SW = 3);
   logic [W-1:0] din;
   logic [SW-1:0] dly;
   logic [W-1:0] dout;
   modport src (output din, output dly, input dout);
   modport line (input din, input dly, output dout);
endinterface

// ===== rtl/hdm_mode_regs.sv
// Mode register bank with two-wire serial slave and the video path it steers.
`timescale 1ns/1ps
module hdm_mode_regs
   import hdm_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   // Arbitrary revision value.
   parameter logic REVISION = 1'b0,
   parameter int unsigned LINE_PIXELS = 2200,
   parameter int unsigned FRAME_LINES = 1125,
   parameter int unsigned HSYNC_PIXELS = 44,
   parameter int unsigned HATCH_SHIFT = 4
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic std_is_720p,
   input wire logic [hdm_pkg::PIX_W-1:0] luma_input_pins,
   input wire logic [hdm_pkg::PIX_W-1:0] red_diff_input_pins,
   input wire logic [hdm_pkg::PIX_W-1:0] muxed_chroma_input_pins,
   output logic [hdm_pkg::PIX_W-1:0] dac_a_code,
   output logic [hdm_pkg::PIX_W-1:0] dac_b_code,
   output logic [hdm_pkg::PIX_W-1:0] dac_c_code,
   output logic dac_a_power,
   output logic dac_b_power,
   output logic dac_c_power,
   output logic high_definition_select,
   output logic rgb_input_select,
   output logic colour_sync_insert,
   output logic hsync_n,
   output logic timing_reset_pulse
);
   import hdm_pkg::*;

   localparam int unsigned HW = $clog2(LINE_PIXELS);
   localparam int unsigned VW = $clog2(FRAME_LINES + 1);

   if (LINE_PIXELS < 2 || FRAME_LINES < VBI_LAST_720P || HSYNC_PIXELS >= LINE_PIXELS) begin : g_bad
      $error("Line or frame size too small for the timing counters.");
   end

   // Serial pins pass two flip-flops; the third copy is only for edge detection.
   logic scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_s1_ff <= scl_in;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= sda_in;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_s2_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s2_ff & scl_d_ff;
   assign bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
   assign bus_stop = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

   hdm_ser_state_t ser_state_ff, nxt_ser_state;
   logic [3:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] rx_ff, nxt_rx, tx_ff, nxt_tx, rd_data;
   logic [REG_AW-1:0] ptr_ff, nxt_ptr;
   logic oe_ff, nxt_oe, nack_ff, nxt_nack, wr_stb;
   logic [7:0] pixel_pattern_reg_ff, delay_reg_ff, scan_dac_reg_ff, counter_reset_reg_ff, colour_config_reg_ff;
   logic [7:0] colour_y_ff, colour_cr_ff, colour_cb_ff;

   always_comb begin
      rd_data = 8'h00;
      unique case (ptr_ff)
         ADDR_PIXEL_PATTERN: rd_data = pixel_pattern_reg_ff;
         ADDR_DELAY: rd_data = delay_reg_ff;
         ADDR_SCAN_DAC: rd_data = scan_dac_reg_ff;
         ADDR_COUNTER_RESET: rd_data = counter_reset_reg_ff;
         ADDR_COLOUR_CONFIG: rd_data = {colour_config_reg_ff[7:1], REVISION};
         ADDR_COLOUR_Y: rd_data = colour_y_ff;
         ADDR_COLOUR_CR: rd_data = colour_cr_ff;
         ADDR_COLOUR_CB: rd_data = colour_cb_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // Subaddress auto-increments after each data byte, so several registers fill in one transfer.
   always_comb begin
      nxt_ser_state = ser_state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_ptr = ptr_ff;
      nxt_oe = oe_ff;
      nxt_nack = nack_ff;
      wr_stb = 1'b0;
      if (bus_stop) begin
         nxt_ser_state = HDM_SER_IDLE;
         nxt_oe = 1'b0;
      end else if (bus_start) begin
         nxt_ser_state = HDM_SER_ADDR;
         nxt_bit_cnt = 4'h0;
         nxt_oe = 1'b0;
      end else if (ser_state_ff != HDM_SER_IDLE) begin
         if (scl_rise) begin
            if (bit_cnt_ff < BIT_COUNT_ACK) begin
               nxt_rx = {rx_ff[6:0], sda_s2_ff};
            end else begin
               nxt_nack = sda_s2_ff;
            end
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
         end else if (scl_fall) begin
            if (bit_cnt_ff == BIT_COUNT_ACK) begin
               unique case (ser_state_ff)
                  HDM_SER_ADDR: begin
                     if (rx_ff[7:1] == DEV_ADDR) begin
                        nxt_oe = 1'b1;
                     end else begin
                        nxt_ser_state = HDM_SER_IDLE;
                     end
                  end
                  HDM_SER_SUB: begin
                     nxt_ptr = rx_ff[REG_AW-1:0];
                     nxt_oe = 1'b1;
                  end
                  HDM_SER_WR: begin
                     wr_stb = 1'b1;
                     nxt_ptr = ptr_ff + 5'h01;
                     nxt_oe = 1'b1;
                  end
                  default: nxt_oe = 1'b0;
               endcase
            end else if (bit_cnt_ff == BIT_COUNT_END) begin
               nxt_bit_cnt = 4'h0;
               nxt_oe = 1'b0;
               unique case (ser_state_ff)
                  HDM_SER_ADDR: begin
                     if (rx_ff[0]) begin
                        nxt_ser_state = HDM_SER_RD;
                        nxt_tx = rd_data;
                        nxt_oe = ~rd_data[7];
                     end else begin
                        nxt_ser_state = HDM_SER_SUB;
                     end
                  end
                  HDM_SER_SUB: nxt_ser_state = HDM_SER_WR;
                  HDM_SER_WR: nxt_ser_state = HDM_SER_WR;
                  default: begin
                     if (nack_ff) begin
                        nxt_ser_state = HDM_SER_IDLE;
                     end else begin
                        nxt_ptr = ptr_ff + 5'h01;
                        nxt_tx = rd_data;
                        nxt_oe = ~rd_data[7];
                     end
                  end
               endcase
            end else if (ser_state_ff == HDM_SER_RD) begin
               nxt_tx = {tx_ff[6:0], 1'b0};
               nxt_oe = ~tx_ff[6];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ser_state_ff <= HDM_SER_IDLE;
         bit_cnt_ff <= 4'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 5'h00;
         oe_ff <= 1'b0;
         nack_ff <= 1'b0;
      end else begin
         ser_state_ff <= nxt_ser_state;
         bit_cnt_ff <= nxt_bit_cnt;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         ptr_ff <= nxt_ptr;
         oe_ff <= nxt_oe;
         nack_ff <= nxt_nack;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = oe_ff;

   // Reserved bits are masked on write and read as zero.
   logic [7:0] nxt_pp, nxt_dl, nxt_sd, nxt_cr, nxt_cc, nxt_cy, nxt_ccr, nxt_ccb;
   always_comb begin
      nxt_pp = pixel_pattern_reg_ff;
      nxt_dl = delay_reg_ff;
      nxt_sd = scan_dac_reg_ff;
      nxt_cr = counter_reset_reg_ff;
      nxt_cc = colour_config_reg_ff;
      nxt_cy = colour_y_ff;
      nxt_ccr = colour_cr_ff;
      nxt_ccb = colour_cb_ff;
      if (wr_stb) begin
         unique case (ptr_ff)
            ADDR_PIXEL_PATTERN: nxt_pp = rx_ff & MASK_PIXEL_PATTERN;
            ADDR_DELAY: nxt_dl = rx_ff & MASK_DELAY;
            ADDR_SCAN_DAC: nxt_sd = rx_ff & MASK_SCAN_DAC;
            ADDR_COUNTER_RESET: nxt_cr = rx_ff & MASK_COUNTER_RESET;
            ADDR_COLOUR_CONFIG: nxt_cc = rx_ff & MASK_COLOUR_CONFIG;
            ADDR_COLOUR_Y: nxt_cy = rx_ff;
            ADDR_COLOUR_CR: nxt_ccr = rx_ff;
            ADDR_COLOUR_CB: nxt_ccb = rx_ff;
            default: nxt_pp = pixel_pattern_reg_ff;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pixel_pattern_reg_ff <= RST_PIXEL_PATTERN;
         delay_reg_ff <= RST_DELAY;
         scan_dac_reg_ff <= RST_SCAN_DAC;
         counter_reset_reg_ff <= RST_COUNTER_RESET;
         colour_config_reg_ff <= RST_COLOUR_CONFIG;
         colour_y_ff <= RST_COLOUR_Y;
         colour_cr_ff <= RST_COLOUR_CR;
         colour_cb_ff <= RST_COLOUR_CB;
      end else begin
         pixel_pattern_reg_ff <= nxt_pp;
         delay_reg_ff <= nxt_dl;
         scan_dac_reg_ff <= nxt_sd;
         counter_reset_reg_ff <= nxt_cr;
         colour_config_reg_ff <= nxt_cc;
         colour_y_ff <= nxt_cy;
         colour_cr_ff <= nxt_ccr;
         colour_cb_ff <= nxt_ccb;
      end
   end

   // Timing counters; the reset sequence must see a rise before the fall that fires it.
   logic trst_prev_ff, nxt_trst_prev, trst_armed_ff, nxt_trst_armed, trst_pulse;
   logic [HW-1:0] h_cnt_ff, nxt_h_cnt;
   logic [VW-1:0] v_cnt_ff, nxt_v_cnt;
   logic trst_bit;
   assign trst_bit = counter_reset_reg_ff[BIT_TIMING_RESET];

   always_comb begin
      nxt_trst_prev = trst_bit;
      nxt_trst_armed = trst_armed_ff;
      trst_pulse = 1'b0;
      if (trst_bit && !trst_prev_ff) begin
         nxt_trst_armed = 1'b1;
      end else if (!trst_bit && trst_prev_ff && trst_armed_ff) begin
         trst_pulse = 1'b1;
         nxt_trst_armed = 1'b0;
      end
      nxt_h_cnt = h_cnt_ff;
      nxt_v_cnt = v_cnt_ff;
      if (trst_pulse) begin
         nxt_h_cnt = '0;
         nxt_v_cnt = VW'(1);
      end else if (h_cnt_ff == HW'(LINE_PIXELS - 1)) begin
         nxt_h_cnt = '0;
         nxt_v_cnt = (v_cnt_ff == VW'(FRAME_LINES)) ? VW'(1) : v_cnt_ff + VW'(1);
      end else begin
         nxt_h_cnt = h_cnt_ff + HW'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         trst_prev_ff <= 1'b0;
         trst_armed_ff <= 1'b0;
         h_cnt_ff <= '0;
         v_cnt_ff <= VW'(1);
      end else begin
         trst_prev_ff <= nxt_trst_prev;
         trst_armed_ff <= nxt_trst_armed;
         h_cnt_ff <= nxt_h_cnt;
         v_cnt_ff <= nxt_v_cnt;
      end
   end

   // Pixel source selection; gate, pattern and blanking all act before the delay lines.
   logic gate, fmt_444, pat_en, pat_solid, vbi_open, rgb, swap, in_vbi, on_grid;
   logic [PIX_W-1:0] y_src, b_src, c_src, pat_y, pat_b, pat_c;
   assign gate = pixel_pattern_reg_ff[BIT_PIXEL_GATE];
   assign fmt_444 = pixel_pattern_reg_ff[BIT_INPUT_FORMAT];
   assign pat_en = pixel_pattern_reg_ff[BIT_PATTERN_EN];
   assign pat_solid = pixel_pattern_reg_ff[BIT_PATTERN_SHAPE];
   assign vbi_open = pixel_pattern_reg_ff[BIT_VBI_OPEN];
   assign rgb = colour_config_reg_ff[BIT_RGB_IN];
   assign swap = colour_config_reg_ff[BIT_COLOUR_SWAP];

   always_comb begin
      if (std_is_720p) begin
         in_vbi = (v_cnt_ff >= VW'(VBI_FIRST_720P)) && (v_cnt_ff <= VW'(VBI_LAST_720P));
      end else begin
         in_vbi = (v_cnt_ff >= VW'(VBI_FIRST_1080I)) && (v_cnt_ff <= VW'(VBI_LAST_1080I));
      end
      on_grid = (h_cnt_ff[HATCH_SHIFT-1:0] == '0) || (v_cnt_ff[HATCH_SHIFT-1:0] == '0);
      // Pattern colour registers are 8-bit; they map onto the top of the 10-bit code.
      pat_y = {colour_y_ff, 2'b00};
      pat_b = swap ? {colour_cb_ff, 2'b00} : {colour_cr_ff, 2'b00};
      pat_c = swap ? {colour_cr_ff, 2'b00} : {colour_cb_ff, 2'b00};
      if (!pat_solid && !on_grid) begin
         pat_y = LUMA_BLACK;
         pat_b = CHROMA_BLACK;
         pat_c = CHROMA_BLACK;
      end
      y_src = luma_input_pins;
      if (rgb) begin
         b_src = red_diff_input_pins;
         c_src = muxed_chroma_input_pins;
      end else if (fmt_444) begin
         b_src = swap ? muxed_chroma_input_pins : red_diff_input_pins;
         c_src = swap ? red_diff_input_pins : muxed_chroma_input_pins;
      end else begin
         b_src = CHROMA_BLACK;
         c_src = muxed_chroma_input_pins;
      end
      if (!gate || (in_vbi && !vbi_open && !pat_en)) begin
         y_src = LUMA_BLACK;
         b_src = rgb ? LUMA_BLACK : CHROMA_BLACK;
         c_src = rgb ? LUMA_BLACK : CHROMA_BLACK;
      end else if (pat_en) begin
         y_src = pat_y;
         b_src = pat_b;
         c_src = pat_c;
      end
   end

   hdm_dly_if #(.W(PIX_W), .SW(DLY_FIELD_W)) y_dly ();
   hdm_dly_if #(.W(PIX_W), .SW(DLY_FIELD_W)) b_dly ();
   hdm_dly_if #(.W(PIX_W), .SW(DLY_FIELD_W)) c_dly ();
   assign y_dly.din = y_src;
   assign b_dly.din = b_src;
   assign c_dly.din = c_src;
   assign y_dly.dly = delay_reg_ff[LUMA_DLY_LSB +: DLY_FIELD_W];
   assign b_dly.dly = delay_reg_ff[CHROMA_DLY_LSB +: DLY_FIELD_W];
   assign c_dly.dly = delay_reg_ff[CHROMA_DLY_LSB +: DLY_FIELD_W];

   hdm_delay_line #(.W(PIX_W), .SW(DLY_FIELD_W), .DEPTH(MAX_DELAY)) u_y_dly (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .port(y_dly.line)
   );
   hdm_delay_line #(.W(PIX_W), .SW(DLY_FIELD_W), .DEPTH(MAX_DELAY)) u_b_dly (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .port(b_dly.line)
   );
   hdm_delay_line #(.W(PIX_W), .SW(DLY_FIELD_W), .DEPTH(MAX_DELAY)) u_c_dly (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .port(c_dly.line)
   );

   // A powered-down DAC sees a zero code so it cannot draw current from stale data.
   logic [PIX_W-1:0] dac_a_ff, dac_b_ff, dac_c_ff, nxt_dac_a, nxt_dac_b, nxt_dac_c;
   logic hsync_n_ff, nxt_hsync_n;
   always_comb begin
      nxt_dac_a = scan_dac_reg_ff[BIT_DAC_A] ? y_dly.dout : PIX_ZERO;
      nxt_dac_b = scan_dac_reg_ff[BIT_DAC_B] ? b_dly.dout : PIX_ZERO;
      nxt_dac_c = scan_dac_reg_ff[BIT_DAC_C] ? c_dly.dout : PIX_ZERO;
      nxt_hsync_n = !(h_cnt_ff < HW'(HSYNC_PIXELS));
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dac_a_ff <= PIX_ZERO;
         dac_b_ff <= PIX_ZERO;
         dac_c_ff <= PIX_ZERO;
         hsync_n_ff <= 1'b1;
      end else begin
         dac_a_ff <= nxt_dac_a;
         dac_b_ff <= nxt_dac_b;
         dac_c_ff <= nxt_dac_c;
         hsync_n_ff <= nxt_hsync_n;
      end
   end

   assign dac_a_code = dac_a_ff;
   assign dac_b_code = dac_b_ff;
   assign dac_c_code = dac_c_ff;
   assign dac_a_power = scan_dac_reg_ff[BIT_DAC_A];
   assign dac_b_power = scan_dac_reg_ff[BIT_DAC_B];
   assign dac_c_power = scan_dac_reg_ff[BIT_DAC_C];
   assign high_definition_select = scan_dac_reg_ff[BIT_HD_SELECT];
   assign rgb_input_select = rgb;
   assign colour_sync_insert = colour_config_reg_ff[BIT_SYNC_INSERT] & ~rgb;
   assign hsync_n = hsync_n_ff;
   assign timing_reset_pulse = trst_pulse;
endmodule // hdm_mode_regs

// ===== rtl/hdm_pkg.sv
// Package with register map, field positions, reset values and video levels of the HDTV mode register bank.
package hdm_pkg;
   localparam int unsigned REG_AW = 5;
   localparam int unsigned REG_DW = 8;
   localparam int unsigned PIX_W = 10;
   localparam logic [4:0] ADDR_PIXEL_PATTERN = 5'h01;
   localparam logic [4:0] ADDR_DELAY = 5'h02;
   localparam logic [4:0] ADDR_SCAN_DAC = 5'h03;
   localparam logic [4:0] ADDR_COUNTER_RESET = 5'h04;
   localparam logic [4:0] ADDR_COLOUR_CONFIG = 5'h05;
   localparam logic [4:0] ADDR_COLOUR_Y = 5'h06;
   localparam logic [4:0] ADDR_COLOUR_CR = 5'h07;
   localparam logic [4:0] ADDR_COLOUR_CB = 5'h08;
   localparam logic [7:0] RST_PIXEL_PATTERN = 8'h00;
   localparam logic [7:0] RST_DELAY = 8'h00;
   localparam logic [7:0] RST_SCAN_DAC = 8'h38;
   localparam logic [7:0] RST_COUNTER_RESET = 8'h00;
   localparam logic [7:0] RST_COLOUR_CONFIG = 8'h00;
   localparam logic [7:0] RST_COLOUR_Y = 8'hA0;
   localparam logic [7:0] RST_COLOUR_CR = 8'h80;
   localparam logic [7:0] RST_COLOUR_CB = 8'h80;
   localparam logic [7:0] MASK_PIXEL_PATTERN = 8'h1F;
   localparam logic [7:0] MASK_DELAY = 8'h3F;
   localparam logic [7:0] MASK_SCAN_DAC = 8'h39;
   localparam logic [7:0] MASK_COUNTER_RESET = 8'h01;
   localparam logic [7:0] MASK_COLOUR_CONFIG = 8'h0E;
   localparam int unsigned BIT_PIXEL_GATE = 0;
   localparam int unsigned BIT_INPUT_FORMAT = 1;
   localparam int unsigned BIT_PATTERN_EN = 2;
   localparam int unsigned BIT_PATTERN_SHAPE = 3;
   localparam int unsigned BIT_VBI_OPEN = 4;
   localparam int unsigned LUMA_DLY_LSB = 0;
   localparam int unsigned CHROMA_DLY_LSB = 3;
   localparam int unsigned DLY_FIELD_W = 3;
   localparam int unsigned BIT_HD_SELECT = 0;
   localparam int unsigned BIT_DAC_A = 3;
   localparam int unsigned BIT_DAC_B = 4;
   localparam int unsigned BIT_DAC_C = 5;
   localparam int unsigned BIT_TIMING_RESET = 0;
   localparam int unsigned BIT_REVISION = 0;
   localparam int unsigned BIT_RGB_IN = 1;
   localparam int unsigned BIT_SYNC_INSERT = 2;
   localparam int unsigned BIT_COLOUR_SWAP = 3;
   localparam int unsigned MAX_DELAY = 4;
   localparam logic [9:0] LUMA_BLACK = 10'h040;
   localparam logic [9:0] CHROMA_BLACK = 10'h200;
   localparam logic [9:0] PIX_ZERO = 10'h000;
   localparam int unsigned VBI_FIRST_1080I = 7;
   localparam int unsigned VBI_LAST_1080I = 20;
   localparam int unsigned VBI_FIRST_720P = 6;
   localparam int unsigned VBI_LAST_720P = 25;
   localparam logic [3:0] BIT_COUNT_ACK = 4'h8;
   localparam logic [3:0] BIT_COUNT_END = 4'h9;
   typedef enum logic [2:0] {
      HDM_SER_IDLE = 3'b000,
      HDM_SER_ADDR = 3'b001,
      HDM_SER_SUB = 3'b010,
      HDM_SER_WR = 3'b011,
      HDM_SER_RD = 3'b100
   } hdm_ser_state_t;
endpackage

// ===== testbench/hdm_mode_regs_monitor.sv
// Checker of the mode register bank port behaviour.
`timescale 1ns/1ps
module hdm_mode_regs_monitor #(parameter int unsigned HSYNC_PIXELS = 44) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic sda_out,
   input wire logic [9:0] dac_a_code,
   input wire logic [9:0] dac_b_code,
   input wire logic [9:0] dac_c_code,
   input wire logic dac_a_power,
   input wire logic dac_b_power,
   input wire logic dac_c_power,
   input wire logic rgb_input_select,
   input wire logic colour_sync_insert,
   input wire logic hsync_n,
   input wire logic timing_reset_pulse
);
   int lo_cnt_ff;
   logic taint_ff;
   // A counter reset may stretch a sync pulse in progress, so that pulse is not measured.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lo_cnt_ff <= 0;
         taint_ff <= 1'h1;
      end else begin
         lo_cnt_ff <= hsync_n ? 0 : lo_cnt_ff + 1;
         taint_ff <= timing_reset_pulse | (taint_ff & !$fell(hsync_n));
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_dac_a_off: assert property ((!dac_a_power) [*2] |-> dac_a_code == 10'h000) else $error("dac a live when off");
   a_dac_b_off: assert property ((!dac_b_power) [*2] |-> dac_b_code == 10'h000) else $error("dac b live when off");
   a_dac_c_off: assert property ((!dac_c_power) [*2] |-> dac_c_code == 10'h000) else $error("dac c live when off");
   a_sync_not_rgb: assert property (colour_sync_insert |-> !rgb_input_select) else $error("sync in rgb");
   a_pulse_single: assert property (timing_reset_pulse |=> !timing_reset_pulse) else $error("long pulse");
   a_counter_restart: assert property (timing_reset_pulse |-> ##[1:3] !hsync_n) else $error("no restart");
   a_sda_open_drain: assert property (sda_out == 1'h0) else $error("sda driven high");
   a_hsync_width: assert property ($rose(hsync_n) && !taint_ff |-> lo_cnt_ff == HSYNC_PIXELS) else $error("hsync width");
endmodule // hdm_mode_regs_monitor
bind hdm_mode_regs hdm_mode_regs_monitor #(.HSYNC_PIXELS(HSYNC_PIXELS)) i_mon (.ref_clk(ref_clk), .nrst(nrst),
   .sda_out(sda_out), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .dac_c_code(dac_c_code),
   .dac_a_power(dac_a_power), .dac_b_power(dac_b_power), .dac_c_power(dac_c_power),
   .rgb_input_select(rgb_input_select), .colour_sync_insert(colour_sync_insert), .hsync_n(hsync_n),
   .timing_reset_pulse(timing_reset_pulse));

// ===== testbench/hdm_ser_host.sv
// Two-wire serial host model that writes and reads the mode registers.
`timescale 1ns/1ps
module hdm_ser_host #(parameter logic [6:0] DEV_ADDR = 7'h2A) (
   input wire logic ref_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   logic ack;
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Eight clocks a phase leave room for the device's input synchronisers.
   task automatic ph(input logic c, input logic d);
      repeat (8) @(posedge ref_clk);
      scl <= c;
      sda <= d;
   endtask
   task automatic bit_io(input logic b, output logic r);
      ph(1'h0, sda);
      ph(1'h0, b);
      ph(1'h1, b);
      repeat (8) @(posedge ref_clk);
      r = sda_line;
   endtask
   task automatic cond(input logic s);
      ph(1'h0, sda);
      ph(1'h0, !s);
      ph(1'h1, !s);
      ph(1'h1, s);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'h1, ack);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      cond(1'h0);
      xfer({DEV_ADDR, 1'h0}, q);
      xfer({3'h0, a}, q);
      xfer(d, q);
      cond(1'h1);
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] q);
      cond(1'h0);
      xfer({DEV_ADDR, 1'h0}, q);
      xfer({3'h0, a}, q);
      cond(1'h0);
      xfer({DEV_ADDR, 1'h1}, q);
      xfer(8'hFF, q);
      cond(1'h1);
   endtask
endmodule // hdm_ser_host

// ===== testbench/tb_hdm_mode_regs.sv
// Self-checking testbench of the mode register bank.
`timescale 1ns/1ps
module tb_hdm_mode_regs;
   import hdm_pkg::*;
   typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} hdm_row_t;
   logic ref_clk = 1'h0;
   logic nrst = 1'h0;
   logic scl, sda, sda_out, sda_oe, pwr_a, pwr_b, pwr_c, hd, rgb, csync, hsync_n, tpulse;
   logic pulse_seen = 1'h0;
   logic [9:0] code_a, code_b, code_c;
   logic [9:0] lum = 10'h3FF, red = 10'h155, mux = 10'h2AA;
   logic [7:0] q;
   logic [7:0] rstv[5] = '{RST_PIXEL_PATTERN, RST_DELAY, RST_SCAN_DAC, RST_COUNTER_RESET, RST_COLOUR_CONFIG};
   hdm_row_t rows[7] = '{'{5'h01, 8'h1F, 8'h1F}, '{5'h02, 8'h3F, 8'h3F}, '{5'h03, 8'h39, 8'h39},
      '{5'h04, 8'hFE, 8'h00}, '{5'h05, 8'h0F, 8'h0E}, '{5'h07, 8'h5A, 8'h5A}, '{5'h1F, 8'h55, 8'h00}};
   int miscompares = 0;
   int checked = 0;
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (tpulse) pulse_seen <= 1'h1;
   hdm_ser_host i_host (.ref_clk(ref_clk), .sda_line(sda & ~sda_oe), .scl(scl), .sda(sda));
   hdm_mode_regs #(.LINE_PIXELS(64), .FRAME_LINES(32)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl),
      .sda_in(sda & ~sda_oe), .sda_out(sda_out), .sda_oe(sda_oe), .std_is_720p(1'h0),
      .luma_input_pins(lum), .red_diff_input_pins(red), .muxed_chroma_input_pins(mux),
      .dac_a_code(code_a), .dac_b_code(code_b), .dac_c_code(code_c), .dac_a_power(pwr_a), .dac_b_power(pwr_b),
      .dac_c_power(pwr_c), .high_definition_select(hd), .rgb_input_select(rgb), .colour_sync_insert(csync),
      .hsync_n(hsync_n), .timing_reset_pulse(tpulse));
   task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'h1;
      repeat (5) @(posedge ref_clk);
      foreach (rows[i]) begin
         i_host.wr(rows[i].a, rows[i].d);
         i_host.rd(rows[i].a, q);
         cmp("readback", {2'h0, rows[i].e}, {2'h0, q});
      end
      cmp("flags", 10'h3E, {4'h0, pwr_c, pwr_b, pwr_a, hd, rgb, csync});
      i_host.wr(5'h05, 8'h04);
      i_host.wr(5'h03, 8'h01);
      cmp("flags", 10'h05, {4'h0, pwr_c, pwr_b, pwr_a, hd, rgb, csync});
      i_host.wr(5'h03, 8'h38);
      i_host.wr(5'h01, 8'h00);
      repeat (20) @(posedge ref_clk);
      cmp("luma black", LUMA_BLACK, code_a);
      cmp("chroma black", CHROMA_BLACK, code_b);
      cmp("chroma black", CHROMA_BLACK, code_c);
      i_host.wr(5'h01, 8'h0D);
      repeat (20) @(posedge ref_clk);
      cmp("pattern y", {RST_COLOUR_Y, 2'h0}, code_a);
      cmp("pattern b", 10'h168, code_b);
      cmp("pattern c", {RST_COLOUR_CB, 2'h0}, code_c);
      i_host.wr(5'h02, 8'h0C);
      i_host.wr(5'h01, 8'h13);
      repeat (20) @(posedge ref_clk);
      cmp("luma pass", 10'h3FF, code_a);
      cmp("red pass", 10'h155, code_b);
      cmp("chroma pass", 10'h2AA, code_c);
      lum <= 10'h123;
      red <= 10'h0F0;
      repeat (5) @(posedge ref_clk);
      cmp("luma delay", 10'h3FF, code_a);
      cmp("chroma delay", 10'h0F0, code_b);
      repeat (3) @(posedge ref_clk);
      cmp("luma delay", 10'h123, code_a);
      i_host.wr(5'h05, 8'h08);
      repeat (20) @(posedge ref_clk);
      cmp("swap b", 10'h2AA, code_b);
      cmp("swap c", 10'h0F0, code_c);
      i_host.wr(5'h04, 8'h01);
      cmp("early pulse", 10'h0, {9'h0, pulse_seen});
      i_host.wr(5'h04, 8'h00);
      cmp("timing pulse", 10'h1, {9'h0, pulse_seen});
      nrst <= 1'h0;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'h1;
      repeat (5) @(posedge ref_clk);
      for (int i = 0; i < 5; i++) begin
         i_host.rd(5'(i + 1), q);
         cmp("reset value", {2'h0, rstv[i]}, {2'h0, q});
      end
      final_report();
   end
endmodule // tb_hdm_mode_regs
